// [src/swpm_ctrl.sv]
// Power mode sequencer of a three-port switch with integrated PHYs
// Function
// RULE1 - Mode field codes 00 to 11 select normal, energy, soft off, saving.
// RULE2 - While hw_power_down_n is low every internal block is powered down.
// RULE3 - After reset the mode field reads 00, normal operation.
// RULE4 - Normal mode keeps clocks, PHY and MAC on and serves host accesses.
// RULE5 - From normal operation the host may write any other mode code.
// RULE6 - In energy detect, no energy beyond the idle delay enters low power.
// RULE7 - Low power turns off all but the receiver's energy detector.
// RULE8 - In low power a 120 ns pulse is sent once per second; the code's pulse is 5 clocks wide, 125 ns at 40 MHz.
// RULE9 - Cable energy in low power returns to energy detect normal state.
// RULE10 - The energy detect normal state can fully transmit and receive.
// RULE11 - Soft power down stops clocks, PHY and MAC and keeps registers.
// RULE12 - Any host access wakes soft power down back to normal operation.
// RULE13 - Power saving needs its code, auto-negotiation on and no cable.
// RULE14 - Power saving keeps all on except the unused PHY receiver block.
// RULE15 - Link activity during power saving powers the PHY receiver back up.
// RULE16 - Bit 3 of a port control register powers that PHY port down alone.
// RULE17 - The idle delay tick period is a design parameter.
`timescale 1ns/1ps
module swpm_ctrl
#(
  parameter int IDLE_TICK_CYCLES = swpm_pkg::IDLE_TICK_CYC,
  parameter int PULSE_PERIOD_CYCLES = swpm_pkg::PULSE_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Power-down pin and line status
  input wire logic hw_power_down_n,
  input wire logic cable_energy,
  input wire logic link_activity,
  input wire logic cable_connected,
  input wire logic autoneg_en,
  // Host register port
  input wire swpm_pkg::swpm_host_req_t host,
  output logic host_ack,
  output logic [7:0] host_rdata,
  // Power controls
  output swpm_pkg::swpm_pwr_t pwr,
  output logic [1:0] port_phy_pd,
  output logic ed_pulse,
  output swpm_pkg::swpm_state_t state
);
  import swpm_pkg::*;

  logic [7:0] port1_control_power;
  logic [7:0] port2_control_power;
  logic [7:0] power_mode_control;
  logic [7:0] idle_entry_delay;
  logic [1:0] mode;
  logic host_ok;
  logic take;
  logic soft_wake;
  logic no_cable;
  swpm_state_t next_state;
  logic [8:0] idle_cnt;
  logic idle_tick;
  logic period_tick;
  logic [2:0] pulse_cnt;

  // Parameters the dividers cannot serve
  generate
    if (IDLE_TICK_CYCLES < 2 || PULSE_PERIOD_CYCLES <= PULSE_CYC)
    begin : g_bad_param
      $error("swpm_ctrl: tick or pulse period too short");
    end
  endgenerate

  // Mode field and request qualification
  assign mode = power_mode_control[MODE_LSB +: 2]; // [RULE1]
  assign host_ok = hw_power_down_n && (state == ST_NORMAL ||
    state == ST_ED_ON || state == ST_SAVE_OFF || state == ST_SAVE_ON);
  assign take = host.req && host_ok; // [RULE4]
  assign soft_wake = hw_power_down_n && state == ST_SOFT_PD && host.req;
  assign no_cable = autoneg_en && !cable_connected;

  // Enables for each sequencer state
  function automatic swpm_pwr_t pwr_of(input swpm_state_t s);
    case (s)
      ST_NORMAL: pwr_of = PWR_FULL; // [RULE4]
      ST_ED_ON: pwr_of = PWR_ED_ON; // [RULE10]
      ST_ED_LOW: pwr_of = PWR_ED_LOW; // [RULE7]
      ST_SOFT_PD: pwr_of = PWR_OFF; // [RULE11]
      ST_SAVE_OFF: pwr_of = PWR_SAVE; // [RULE14]
      ST_SAVE_ON: pwr_of = PWR_FULL;
      ST_HW_PD: pwr_of = PWR_OFF; // [RULE2]
      default: pwr_of = PWR_OFF;
    endcase
  endfunction

  // Next state; the pin overrides every mode
  always_comb
  begin
    next_state = state;
    if (!hw_power_down_n)
    begin
      next_state = ST_HW_PD; // [RULE2]
    end
    else
    begin
      case (state)
        ST_HW_PD: next_state = ST_NORMAL;
        ST_NORMAL:
        begin
          case (mode) // [RULE1] [RULE5]
            MODE_ENERGY: next_state = ST_ED_ON;
            MODE_SOFT_PD: next_state = ST_SOFT_PD;
            MODE_SAVE:
              if (no_cable) next_state = ST_SAVE_OFF; // [RULE13]
            default: next_state = ST_NORMAL;
          endcase
        end
        ST_ED_ON:
        begin
          if (mode != MODE_ENERGY) next_state = ST_NORMAL;
          else if (!cable_energy && idle_cnt > {1'b0, idle_entry_delay})
            next_state = ST_ED_LOW; // [RULE6]
        end
        ST_ED_LOW:
          if (cable_energy) next_state = ST_ED_ON; // [RULE9]
        ST_SOFT_PD:
          if (host.req) next_state = ST_NORMAL; // [RULE12]
        ST_SAVE_OFF:
        begin
          if (mode != MODE_SAVE) next_state = ST_NORMAL;
          else if (link_activity) next_state = ST_SAVE_ON; // [RULE15]
        end
        ST_SAVE_ON:
        begin
          if (mode != MODE_SAVE) next_state = ST_NORMAL;
          else if (no_cable && !link_activity)
            next_state = ST_SAVE_OFF; // [RULE13]
        end
        default: next_state = ST_NORMAL;
      endcase
    end
  end

  // State and block enables; enables are registered beside the state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_NORMAL;
      pwr <= PWR_FULL;
    end
    else
    begin
      state <= next_state;
      pwr <= pwr_of(next_state);
    end
  end

  // Register writes; while the host side is off only a soft power down wake access changes the register, clearing the mode field [RULE11]
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port1_control_power <= PORT_CTRL_RST;
      port2_control_power <= PORT_CTRL_RST;
      power_mode_control <= MODE_CTRL_RST; // [RULE3]
      idle_entry_delay <= IDLE_DELAY_RST;
    end
    else if (soft_wake)
    begin
      power_mode_control[MODE_LSB +: 2] <= MODE_NORMAL; // [RULE12]
    end
    else if (take && host.wr)
    begin
      case (host.addr)
        ADDR_PORT1_CTRL: port1_control_power <= host.wdata;
        ADDR_PORT2_CTRL: port2_control_power <= host.wdata;
        ADDR_MODE_CTRL: power_mode_control <= host.wdata; // [RULE5]
        ADDR_IDLE_DELAY: idle_entry_delay <= host.wdata;
        default: ;
      endcase
    end
  end

  // Read data and acknowledge; unmapped offsets read as zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      host_ack <= 1'b0;
      host_rdata <= 8'h00;
    end
    else
    begin
      host_ack <= take; // [RULE4]
      if (take && !host.wr)
      begin
        case (host.addr)
          ADDR_PORT1_CTRL: host_rdata <= port1_control_power;
          ADDR_PORT2_CTRL: host_rdata <= port2_control_power;
          ADDR_MODE_CTRL: host_rdata <= power_mode_control;
          ADDR_IDLE_DELAY: host_rdata <= idle_entry_delay;
          default: host_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Per-port PHY power down, independent of the global mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_phy_pd <= 2'h0;
    end
    else
    begin
      port_phy_pd <= {port2_control_power[PORT_PD_BIT],
        port1_control_power[PORT_PD_BIT]}; // [RULE16]
    end
  end

  // Idle tick divider; its period is a parameter as the unit is open
  swpm_tick_div #(
    .PERIOD(IDLE_TICK_CYCLES) // [RULE17]
  ) u_idle_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(state == ST_ED_ON && !cable_energy),
    .tick(idle_tick)
  );

  // Idle time counter; one bit wider so "longer than 255" is reachable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_cnt <= 9'h000;
    end
    else if (state != ST_ED_ON || cable_energy)
    begin
      idle_cnt <= 9'h000; // [RULE6]
    end
    else if (idle_tick && idle_cnt != 9'h1ff)
    begin
      idle_cnt <= idle_cnt + 9'h001;
    end
  end

  // One-second period for the low-power pulse
  swpm_tick_div #(
    .PERIOD(PULSE_PERIOD_CYCLES)
  ) u_pulse_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(state == ST_ED_LOW),
    .tick(period_tick)
  );

  // Pulse width counter; a started pulse always runs its full width
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulse_cnt <= 3'h0;
      ed_pulse <= 1'b0;
    end
    else if (period_tick && pulse_cnt == 3'h0)
    begin
      pulse_cnt <= 3'(PULSE_CYC); // [RULE8]
      ed_pulse <= 1'b1;
    end
    else if (pulse_cnt > 3'h1)
    begin
      pulse_cnt <= pulse_cnt - 3'h1;
      ed_pulse <= 1'b1;
    end
    else
    begin
      pulse_cnt <= 3'h0;
      ed_pulse <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_soft_access;
    state == ST_SOFT_PD && host.req && hw_power_down_n;
  endsequence

  sequence s_back_normal;
    state == ST_NORMAL && mode == MODE_NORMAL && !host_ack;
  endsequence

  sequence s_port1_pd_write;
    take && host.wr && host.addr == ADDR_PORT1_CTRL &&
      host.wdata[PORT_PD_BIT];
  endsequence

  chk_mode_decode: assert property ( // [RULE1]
    state == ST_NORMAL && mode == MODE_ENERGY && hw_power_down_n
    |=> state == ST_ED_ON && pwr == PWR_ED_ON)
    else $error("energy detect code not decoded");

  chk_hw_pd_off: assert property ( // [RULE2]
    !hw_power_down_n |=> pwr == PWR_OFF && !host_ack ##1 !host_ack)
    else $error("block left powered while pin low");

  chk_normal_full: assert property ( // [RULE4]
    state == ST_NORMAL |-> pwr == PWR_FULL)
    else $error("normal mode enables wrong");

  chk_idle_entry: assert property ( // [RULE6]
    state == ST_ED_ON && mode == MODE_ENERGY && !cable_energy &&
    hw_power_down_n && idle_cnt > {1'b0, idle_entry_delay}
    |=> state == ST_ED_LOW)
    else $error("idle delay did not enter low power");

  chk_no_early_low: assert property ( // [RULE6]
    state == ST_ED_ON && idle_cnt <= {1'b0, idle_entry_delay}
    |=> state != ST_ED_LOW)
    else $error("low power entered before idle delay");

  chk_low_enables: assert property ( // [RULE7]
    state == ST_ED_LOW |-> pwr == PWR_ED_LOW ##1 !host_ack)
    else $error("low power enables wrong");

  chk_pulse_width: assert property ( // [RULE8]
    $rose(ed_pulse) |-> ed_pulse [*5] ##1 !ed_pulse)
    else $error("low power pulse width wrong");

  chk_energy_wake: assert property ( // [RULE9]
    state == ST_ED_LOW && cable_energy && hw_power_down_n
    |=> state == ST_ED_ON ##0 pwr.phy_rx && pwr.phy_tx)
    else $error("cable energy did not wake");

  chk_soft_wake: assert property ( // [RULE12]
    s_soft_access |=> s_back_normal ##1 pwr == PWR_FULL)
    else $error("host access did not wake soft power down");

  chk_save_guard: assert property ( // [RULE13]
    state == ST_NORMAL && mode == MODE_SAVE && !no_cable &&
    hw_power_down_n |=> state == ST_NORMAL)
    else $error("power saving entered with cable present");

  chk_save_resume: assert property ( // [RULE15]
    state == ST_SAVE_OFF && mode == MODE_SAVE && link_activity &&
    hw_power_down_n |=> pwr == PWR_FULL)
    else $error("link activity did not restore receiver");

  chk_port_pd: assert property ( // [RULE16]
    s_port1_pd_write |=> ##1 port_phy_pd[0])
    else $error("port power down bit not applied");
endmodule

// [src/swpm_pkg.sv]
// Package: constants and types for the switch power mode controller
package swpm_pkg;
  // Clock rate
  localparam int CLK_MHZ = 40;

  // Register offsets
  localparam logic [7:0] ADDR_PORT1_CTRL = 8'h1d;
  localparam logic [7:0] ADDR_PORT2_CTRL = 8'h2d;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hc3;
  localparam logic [7:0] ADDR_IDLE_DELAY = 8'hc4;

  // Field positions
  localparam int MODE_LSB = 4;
  localparam int PORT_PD_BIT = 3;

  // Reset values
  localparam logic [7:0] PORT_CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] IDLE_DELAY_RST = 8'h10;

  // Power mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY = 2'h1;
  localparam logic [1:0] MODE_SOFT_PD = 2'h2;
  localparam logic [1:0] MODE_SAVE = 2'h3;

  // Timing
  localparam int PULSE_NS = 120;
  localparam int PULSE_PERIOD_MS = 1000;
  localparam int IDLE_TICK_US = 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int IDLE_TICK_CYC = IDLE_TICK_US * CLK_MHZ;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_ED_ON = 3'h1,
    ST_ED_LOW = 3'h2,
    ST_SOFT_PD = 3'h3,
    ST_SAVE_OFF = 3'h4,
    ST_SAVE_ON = 3'h5,
    ST_HW_PD = 3'h6
  } swpm_state_t;

  // Power enables of the internal function blocks
  typedef struct packed {
    logic pll_clk;
    logic mac;
    logic host_if;
    logic phy_tx;
    logic phy_rx;
    logic energy_det;
  } swpm_pwr_t;

  localparam swpm_pwr_t PWR_FULL = 6'h3e;
  localparam swpm_pwr_t PWR_ED_ON = 6'h3f;
  localparam swpm_pwr_t PWR_ED_LOW = 6'h01;
  localparam swpm_pwr_t PWR_SAVE = 6'h3c;
  localparam swpm_pwr_t PWR_OFF = 6'h00;

  // Host register request
  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swpm_host_req_t;
endpackage

// [src/swpm_tick_div.sv]
// Divider that gives a one-cycle enable every PERIOD cycles while run
`timescale 1ns/1ps
module swpm_tick_div
#(
  parameter int PERIOD = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  // Enable pulse
  output logic tick
);
  localparam int W = $clog2(PERIOD);

  logic [W-1:0] count;

  // A period below two cycles cannot give a separate tick
  generate
    if (PERIOD < 2)
    begin : g_bad_period
      $error("swpm_tick_div: PERIOD must be at least 2");
    end
  endgenerate

  // Restart from zero whenever run drops, so the first tick is a full period
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (count == W'(PERIOD - 1))
    begin
      count <= '0;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// [verif/swpm_ctrl_tb.sv]
// Self-checking bench for the switch power mode controller
`timescale 1ns/1ps
module swpm_ctrl_tb;
  import swpm_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hw_power_down_n = 1'b1;
  logic autoneg_en = 1'b1;
  logic plugged = 1'b0;
  logic talking = 1'b0;
  logic cable_energy;
  logic link_activity;
  logic cable_connected;
  swpm_host_req_t host = '0;
  logic host_ack;
  logic [7:0] host_rdata;
  swpm_pwr_t pwr;
  logic [1:0] port_phy_pd;
  logic ed_pulse;
  swpm_state_t state;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'ha87a_8a31;
  logic [7:0] adr [5];
  int mreg [4];
  swpm_state_t mst;
  logic [7:0] rd;
  int n;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  swpm_link_partner lp (
    .clk(clk),
    .plugged(plugged),
    .talking(talking),
    .cable_connected(cable_connected),
    .cable_energy(cable_energy),
    .link_activity(link_activity)
  );

  // Short counts keep the run brief
  swpm_ctrl #(.IDLE_TICK_CYCLES(4), .PULSE_PERIOD_CYCLES(20)) DUT (
    .clk(clk),
    .reset_n(reset_n),
    .hw_power_down_n(hw_power_down_n),
    .cable_energy(cable_energy),
    .link_activity(link_activity),
    .cable_connected(cable_connected),
    .autoneg_en(autoneg_en),
    .host(host),
    .host_ack(host_ack),
    .host_rdata(host_rdata),
    .pwr(pwr),
    .port_phy_pd(port_phy_pd),
    .ed_pulse(ed_pulse),
    .state(state)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected block enables for each sequencer state
  function automatic swpm_pwr_t mpwr(input swpm_state_t s);
    case (s)
      ST_ED_ON: return PWR_ED_ON;
      ST_ED_LOW: return PWR_ED_LOW;
      ST_SOFT_PD, ST_HW_PD: return PWR_OFF;
      ST_SAVE_OFF: return PWR_SAVE;
      default: return PWR_FULL;
    endcase
  endfunction

  function automatic int idx(input logic [7:0] a);
    for (int i = 0; i < 4; i++)
      if (adr[i] == a)
        return i;
    return -1;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic cmp_st();
    check({5'h0, state}, {5'h0, mst});
    check({2'h0, pwr}, {2'h0, mpwr(mst)});
  endtask

  // One request cycle; the answer is due at the edge that takes it
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, input logic ack);
    @(posedge clk);
    host <= {1'b1, wr, a, d};
    @(posedge clk);
    host <= '0;
    #1;
    check({7'h0, host_ack}, {7'h0, ack});
    rd = host_rdata;
    if (ack && wr && idx(a) >= 0)
      mreg[idx(a)] = d;
  endtask

  task automatic rchk(input logic [7:0] a);
    acc(1'b0, a, 8'h00, 1'b1);
    check(rd, (idx(a) < 0) ? 8'h00 : mreg[idx(a)][7:0]);
  endtask

  task automatic wait_st(input int lim);
    n = 0;
    while (state !== mst)
    begin
      cyc(1);
      n++;
      if (n > lim)
      begin
        error_cnt++;
        $display("wrong value at %0t: state wait ran out", $time);
        wrap_up();
      end
    end
  endtask

  initial
  begin
    adr = '{ADDR_PORT1_CTRL, ADDR_PORT2_CTRL, ADDR_MODE_CTRL,
            ADDR_IDLE_DELAY, 8'h7e};
    mreg = '{0, 0, 0, 16};
    mst = ST_NORMAL;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    cmp_st();
    for (int i = 0; i < 5; i++)
      rchk(adr[i]);
    // Random port and mode control writes; the mode field is kept at 00
    for (int i = 0; i < 9; i++)
    begin
      seed = xs(seed);
      acc(1'b1, adr[i % 3],
          seed[7:0] & ((i % 3 == 2) ? 8'hcf : 8'hff), 1'b1);
      cyc(2);
      check({6'h0, port_phy_pd}, {6'h0, mreg[1][3], mreg[0][3]});
      cmp_st();
    end
    acc(1'b1, adr[4], seed[15:8], 1'b1);
    // Directed port writes so the port 1 power-down bit is seen set and the port 2 bit clear
    acc(1'b1, ADDR_PORT1_CTRL, seed[23:16] | 8'h08, 1'b1);
    acc(1'b1, ADDR_PORT2_CTRL, seed[31:24] & 8'hf7, 1'b1);
    cyc(2);
    check({6'h0, port_phy_pd}, {6'h0, mreg[1][3], mreg[0][3]});
    for (int i = 0; i < 5; i++)
      rchk(adr[i]);
    // Energy detect: idle entry, beacon pulse, wake on energy
    acc(1'b1, ADDR_IDLE_DELAY, 8'h02, 1'b1);
    acc(1'b1, ADDR_MODE_CTRL, 8'h10, 1'b1);
    mst = ST_ED_ON;
    cyc(1);
    cmp_st();
    mst = ST_ED_LOW;
    wait_st(40);
    check({7'h0, n >= 8 && n <= 20}, 8'h01);
    cmp_st();
    n = 0;
    repeat (26)
    begin
      cyc(1);
      n += (ed_pulse === 1'b1);
    end
    check(n[7:0], 8'h05);
    acc(1'b0, ADDR_IDLE_DELAY, 8'h00, 1'b0);
    @(posedge clk);
    plugged <= 1'b1;
    talking <= 1'b1;
    mst = ST_ED_ON;
    wait_st(4);
    cmp_st();
    // Soft power down and wake by a dummy access
    acc(1'b1, ADDR_MODE_CTRL, 8'h20, 1'b1);
    // A code change in energy detect passes through normal first
    mst = ST_SOFT_PD;
    cyc(2);
    cmp_st();
    acc(1'b0, ADDR_PORT1_CTRL, 8'h00, 1'b0);
    mreg[2] = mreg[2] & 'hcf;
    mst = ST_NORMAL;
    cmp_st();
    for (int i = 0; i < 4; i++)
      rchk(adr[i]);
    // Power saving needs auto-negotiation and no cable
    @(posedge clk);
    autoneg_en <= 1'b0;
    acc(1'b1, ADDR_MODE_CTRL, 8'h30, 1'b1);
    @(posedge clk);
    plugged <= 1'b0;
    talking <= 1'b0;
    cyc(4);
    cmp_st();
    @(posedge clk);
    autoneg_en <= 1'b1;
    mst = ST_SAVE_OFF;
    wait_st(4);
    cmp_st();
    rchk(ADDR_PORT2_CTRL);
    @(posedge clk);
    plugged <= 1'b1;
    talking <= 1'b1;
    mst = ST_SAVE_ON;
    wait_st(10);
    cmp_st();
    // Hardware power-down pin overrides everything
    @(posedge clk);
    hw_power_down_n <= 1'b0;
    mst = ST_HW_PD;
    wait_st(3);
    cmp_st();
    acc(1'b0, ADDR_IDLE_DELAY, 8'h00, 1'b0);
    @(posedge clk);
    hw_power_down_n <= 1'b1;
    mst = ST_NORMAL;
    wait_st(3);
    cmp_st();
    wrap_up();
  end
endmodule

// [verif/swpm_link_partner.sv]
// Cable and remote link partner model that drives the line status
`timescale 1ns/1ps
module swpm_link_partner
(
  // Clock
  input wire logic clk,
  // Scenario control
  input wire logic plugged,
  input wire logic talking,
  // Line status
  output logic cable_connected,
  output logic cable_energy,
  output logic link_activity
);
  logic [3:0] age;

  // Quiet line at time zero, so no unknown reaches the sequencer
  initial
  begin
    age = 4'h0;
    cable_connected = 1'b0;
    cable_energy = 1'b0;
    link_activity = 1'b0;
  end

  // Energy needs a cable and a live far end; link activity lags it
  always @(posedge clk)
  begin
    cable_connected <= plugged;
    cable_energy <= plugged & talking;
    age <= (plugged & talking) ? ((age == 4'hf) ? age : age + 4'h1) : 4'h0;
    link_activity <= (age > 4'h2);
  end
endmodule
